// ===== pkg/ltg_pkg.sv
// Notes on behaviour
// - request valid and data held until ready
// - pause field bits 0-7, wait field+1
// - request is 7 zeros, stop bit, pause
// - core raises ready when it accepts request
// - control-block valid only after configured gap
// - block number counts from zero up to 8
// - word is 4 zeros, block number, data
// - core readies control block when it can take
// - expected frame data from lfsr per beat
// - frame starts on valid; keep only on last
// - register data, compare, count mismatches 8-bit
// - data error counter saturates at 255
// - reset clears the error counter
// - end-of-frame marker raised only together with valid
// - streaming compares only while valid
// - flow message lfsr check, own 8-bit counter
// - message keep valid on last word only
// - control-block mismatch bumps own 8-bit counter
// - control-block compare only while valid
// - received block is 4 zeros, number, data
// - flow fsm waits, on, then off via ready
package ltg_pkg;
  localparam int LANES = 1;
  localparam int DATA_W = 64 * LANES;
  localparam int KEEP_W = 8 * LANES;
  localparam int FC_W = 16;
  localparam int ERR_W = 8;
  localparam logic [ERR_W-1:0] ERR_MAX = 8'hff;
  localparam logic [ERR_W-1:0] ERR_RESET = 8'h00;
  localparam int BLK_NUM_W = 4;
  localparam int KDATA_W = 56 * LANES;
  localparam logic [BLK_NUM_W-1:0] BLK_LAST = 4'h8;
  localparam logic [3:0] BLK_PAD = 4'h0;
  localparam logic [6:0] FC_PAD = 7'h00;
  localparam logic [7:0] FC_PAUSE = 8'h0f;
  localparam logic [7:0] FC_ON_GAP = 8'h40;
  localparam logic [7:0] FC_OFF_GAP = 8'h40;
  localparam logic [15:0] CTRL_GAP_DEFAULT = 16'h0020;
  localparam logic [KDATA_W-1:0] KDATA_CONST = 56'ha5c3_5a3c_0f1e_2d;
  localparam logic [15:0] LFSR_SEED = 16'habe0;
  localparam logic [15:0] UFC_SEED = 16'h1d2b;

  typedef enum logic [1:0] {LTG_FC_WAIT, LTG_FC_ON, LTG_FC_OFF} ltg_fc_type;

  function automatic logic [15:0] ltg_lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[14] ^ s[12] ^ s[3]};
  endfunction

  function automatic logic [DATA_W-1:0] ltg_expand(input logic [15:0] s);
    return {LANES * 4{s}};
  endfunction

  function automatic logic [ERR_W-1:0] ltg_sat_inc(input logic [ERR_W-1:0] c);
    return (c == ERR_MAX) ? c : ERR_W'(c + 8'h01);
  endfunction

  function automatic logic [DATA_W-1:0] ltg_kword(input logic [BLK_NUM_W-1:0] n);
    return {BLK_PAD, n, KDATA_CONST};
  endfunction
endpackage

// ===== pkg/ltg_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ltg_link_if;
  import ltg_pkg::*;
  logic [FC_W-1:0] fc_tdata;
  logic fc_tvalid;
  logic fc_tready;
  logic [DATA_W-1:0] k_tx_tdata;
  logic k_tx_tvalid;
  logic k_tx_tready;
  logic [DATA_W-1:0] rx_tdata;
  logic [KEEP_W-1:0] rx_tkeep;
  logic rx_tvalid;
  logic rx_tlast;
  logic [DATA_W-1:0] ufc_rx_tdata;
  logic [KEEP_W-1:0] ufc_rx_tkeep;
  logic ufc_rx_tvalid;
  logic ufc_rx_tlast;
  logic [DATA_W-1:0] k_rx_tdata;
  logic k_rx_tvalid;
  logic channel_up;
  modport gen_chk (
    output fc_tdata, fc_tvalid, k_tx_tdata, k_tx_tvalid,
    input fc_tready, k_tx_tready, rx_tdata, rx_tkeep, rx_tvalid, rx_tlast,
    input ufc_rx_tdata, ufc_rx_tkeep, ufc_rx_tvalid, ufc_rx_tlast,
    input k_rx_tdata, k_rx_tvalid, channel_up
  );
  modport core (
    input fc_tdata, fc_tvalid, k_tx_tdata, k_tx_tvalid,
    output fc_tready, k_tx_tready, rx_tdata, rx_tkeep, rx_tvalid, rx_tlast,
    output ufc_rx_tdata, ufc_rx_tkeep, ufc_rx_tvalid, ufc_rx_tlast,
    output k_rx_tdata, k_rx_tvalid, channel_up
  );
endinterface
`default_nettype wire

// ===== rtl/ltg_gen_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ltg_gen_chk
  import ltg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [15:0] ctrl_block_gap,
  input wire logic stream_mode,
  ltg_link_if.gen_chk lnk,
  output logic [ERR_W-1:0] data_err_count,
  output logic [ERR_W-1:0] ufc_err_count,
  output logic [ERR_W-1:0] ctrl_err_count,
  output logic [1:0] fc_state
);
  // =====================================================
  // flow-control request generator
  ltg_fc_type fc_st;
  logic [7:0] fc_cnt;
  logic fc_stop;
  logic fc_pend;
  logic fc_acc;
  assign fc_acc = lnk.fc_tvalid && lnk.fc_tready;
  assign lnk.fc_tvalid = fc_pend;
  assign lnk.fc_tdata = {FC_PAD, fc_stop, FC_PAUSE};
  assign fc_state = fc_st;

  // while a request is pending, state moves only when it is accepted or channel_up drops, so data never changes while pending
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fc_st <= LTG_FC_WAIT;
      fc_cnt <= 8'h00;
      fc_stop <= 1'b0;
      fc_pend <= 1'b0;
    end else begin
      case (fc_st)
        LTG_FC_WAIT: begin
          if (lnk.channel_up && lnk.rx_tvalid) begin
            fc_st <= LTG_FC_ON;
            fc_cnt <= FC_ON_GAP;
          end
        end
        LTG_FC_ON: begin
          if (fc_pend) begin
            if (fc_acc) begin
              fc_pend <= 1'b0;
              fc_st <= LTG_FC_OFF;
              fc_cnt <= FC_OFF_GAP;
            end
          end else if (fc_cnt != 8'h00) begin
            fc_cnt <= fc_cnt - 8'h01;
          end else begin
            fc_stop <= 1'b1;
            fc_pend <= 1'b1;
          end
        end
        LTG_FC_OFF: begin
          if (fc_pend) begin
            if (fc_acc) begin
              fc_pend <= 1'b0;
              fc_st <= LTG_FC_ON;
              fc_cnt <= FC_ON_GAP;
            end
          end else if (fc_cnt != 8'h00) begin
            fc_cnt <= fc_cnt - 8'h01;
          end else begin
            fc_stop <= 1'b0;
            fc_pend <= 1'b1;
          end
        end
        default: begin
          fc_st <= LTG_FC_WAIT;
          fc_pend <= 1'b0;
        end
      endcase
      if (!lnk.channel_up) begin
        fc_st <= LTG_FC_WAIT;
        fc_pend <= 1'b0;
        fc_stop <= 1'b0;
      end
    end
  end

  // =====================================================
  // control-block generator
  logic [15:0] k_gap;
  logic [BLK_NUM_W-1:0] k_num;
  logic k_valid;
  assign lnk.k_tx_tvalid = k_valid;
  assign lnk.k_tx_tdata = ltg_kword(k_num);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      k_gap <= 16'h0000;
      k_num <= 4'h0;
      k_valid <= 1'b0;
    end else if (!lnk.channel_up) begin
      k_gap <= 16'h0000;
      k_num <= 4'h0;
      k_valid <= 1'b0;
    end else if (k_valid) begin
      if (lnk.k_tx_tready) begin
        k_valid <= 1'b0;
        k_gap <= 16'h0000;
        // block number stops at its last value
        if (k_num != BLK_LAST) begin
          k_num <= k_num + 4'h1;
        end
      end
    end else if (k_gap >= ctrl_block_gap) begin
      k_valid <= 1'b1;
    end else begin
      k_gap <= k_gap + 16'h0001;
    end
  end

  // =====================================================
  // frame and stream data checker
  logic [15:0] rx_lfsr;
  logic [DATA_W-1:0] rx_q;
  logic [DATA_W-1:0] rx_exp;
  logic [KEEP_W-1:0] rx_mask;
  logic rx_cmp;
  logic [DATA_W-1:0] rx_exp_now;

  // a function result cannot be part-selected, so the expected word is a net
  assign rx_exp_now = ltg_expand(rx_lfsr);

  // keep only trimmed on the last beat outside stream_mode; all other beats compare every byte
  always_comb begin
    rx_mask = '1;
    if (!stream_mode && lnk.rx_tlast) begin
      rx_mask = lnk.rx_tkeep;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_lfsr <= LFSR_SEED;
      rx_q <= '0;
      rx_exp <= '0;
      rx_cmp <= 1'b0;
    end else begin
      rx_cmp <= lnk.rx_tvalid;
      if (lnk.rx_tvalid) begin
        rx_q <= lnk.rx_tdata;
        for (int b = 0; b < KEEP_W; b++) begin
          if (!rx_mask[b]) begin
            rx_q[b*8 +: 8] <= rx_exp_now[b*8 +: 8];
          end
        end
        rx_exp <= rx_exp_now;
        rx_lfsr <= ltg_lfsr_step(rx_lfsr);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_err_count <= ERR_RESET;
    end else if (rx_cmp && rx_q != rx_exp) begin
      data_err_count <= ltg_sat_inc(data_err_count);
    end
  end

  // =====================================================
  // flow message checker
  logic [15:0] ufc_lfsr;
  logic [DATA_W-1:0] ufc_q;
  logic [DATA_W-1:0] ufc_exp;
  logic ufc_cmp;
  logic [DATA_W-1:0] ufc_exp_now;

  assign ufc_exp_now = ltg_expand(ufc_lfsr);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ufc_lfsr <= UFC_SEED;
      ufc_q <= '0;
      ufc_exp <= '0;
      ufc_cmp <= 1'b0;
    end else begin
      ufc_cmp <= lnk.ufc_rx_tvalid;
      if (lnk.ufc_rx_tvalid) begin
        ufc_q <= lnk.ufc_rx_tdata;
        // bytes past the message end are not compared
        for (int b = 0; b < KEEP_W; b++) begin
          if (lnk.ufc_rx_tlast && !lnk.ufc_rx_tkeep[b]) begin
            ufc_q[b*8 +: 8] <= ufc_exp_now[b*8 +: 8];
          end
        end
        ufc_exp <= ufc_exp_now;
        ufc_lfsr <= ltg_lfsr_step(ufc_lfsr);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ufc_err_count <= ERR_RESET;
    end else if (ufc_cmp && ufc_q != ufc_exp) begin
      ufc_err_count <= ltg_sat_inc(ufc_err_count);
    end
  end

  // =====================================================
  // control-block checker
  logic [DATA_W-1:0] krx_q;
  logic krx_cmp;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      krx_q <= '0;
      krx_cmp <= 1'b0;
    end else begin
      krx_cmp <= lnk.k_rx_tvalid;
      if (lnk.k_rx_tvalid) begin
        krx_q <= lnk.k_rx_tdata;
      end
    end
  end

  // the block number is accepted as sent; only pad and data are predefined
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_err_count <= ERR_RESET;
    end else if (krx_cmp && krx_q != ltg_kword(krx_q[KDATA_W +: BLK_NUM_W])) begin
      ctrl_err_count <= ltg_sat_inc(ctrl_err_count);
    end
  end
endmodule
`default_nettype wire

// ===== rtl/ltg_core_end.sv
`timescale 1ns/1ps
`default_nettype none
module ltg_core_end
  import ltg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  ltg_link_if.core lnk,
  input wire logic up,
  input wire logic fc_ready,
  input wire logic k_ready,
  input wire logic [DATA_W-1:0] rx_data,
  input wire logic [KEEP_W-1:0] rx_keep,
  input wire logic rx_valid,
  input wire logic rx_last,
  input wire logic [DATA_W-1:0] ufc_data,
  input wire logic [KEEP_W-1:0] ufc_keep,
  input wire logic ufc_valid,
  input wire logic ufc_last,
  input wire logic [DATA_W-1:0] k_data,
  input wire logic k_valid,
  output logic [FC_W-1:0] fc_taken,
  output logic fc_taken_valid,
  output logic [DATA_W-1:0] k_taken,
  output logic k_taken_valid
);
  // =====================================================
  // core-side drivers, registered; fc_tready and k_tx_tready are combinational
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lnk.channel_up <= 1'b0;
      lnk.rx_tdata <= '0;
      lnk.rx_tkeep <= '0;
      lnk.rx_tvalid <= 1'b0;
      lnk.rx_tlast <= 1'b0;
      lnk.ufc_rx_tdata <= '0;
      lnk.ufc_rx_tkeep <= '0;
      lnk.ufc_rx_tvalid <= 1'b0;
      lnk.ufc_rx_tlast <= 1'b0;
      lnk.k_rx_tdata <= '0;
      lnk.k_rx_tvalid <= 1'b0;
    end else begin
      lnk.channel_up <= up;
      lnk.rx_tdata <= rx_data;
      lnk.rx_tkeep <= rx_last ? rx_keep : '0;
      lnk.rx_tvalid <= rx_valid;
      lnk.rx_tlast <= rx_valid && rx_last;
      lnk.ufc_rx_tdata <= ufc_data;
      lnk.ufc_rx_tkeep <= ufc_last ? ufc_keep : '0;
      lnk.ufc_rx_tvalid <= ufc_valid;
      lnk.ufc_rx_tlast <= ufc_valid && ufc_last;
      lnk.k_rx_tdata <= {BLK_PAD, k_data[KDATA_W +: BLK_NUM_W], k_data[KDATA_W-1:0]};
      lnk.k_rx_tvalid <= k_valid;
    end
  end

  assign lnk.fc_tready = fc_ready && lnk.fc_tvalid;
  assign lnk.k_tx_tready = k_ready;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fc_taken <= '0;
      fc_taken_valid <= 1'b0;
      k_taken <= '0;
      k_taken_valid <= 1'b0;
    end else begin
      fc_taken_valid <= lnk.fc_tvalid && lnk.fc_tready;
      if (lnk.fc_tvalid && lnk.fc_tready) begin
        fc_taken <= lnk.fc_tdata;
      end
      k_taken_valid <= lnk.k_tx_tvalid && k_ready;
      if (lnk.k_tx_tvalid && k_ready) begin
        k_taken <= lnk.k_tx_tdata;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/ltg_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// link monitor
module ltg_link_monitor
  import ltg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [FC_W-1:0] fc_tdata,
  input wire logic fc_tvalid,
  input wire logic fc_tready,
  input wire logic [DATA_W-1:0] k_tx_tdata,
  input wire logic k_tx_tvalid,
  input wire logic k_tx_tready
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic last_stop;
  logic [BLK_NUM_W-1:0] num;
  sequence fc_take;
    fc_tvalid && fc_tready;
  endsequence
  sequence k_take;
    k_tx_tvalid && k_tx_tready;
  endsequence
  // history assumes channel_up stays high between resets
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      last_stop <= 1'b0;
    end else if (fc_tvalid && fc_tready) begin
      last_stop <= fc_tdata[8];
    end
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      num <= 4'h0;
    end else if (k_tx_tvalid && k_tx_tready && num != BLK_LAST) begin
      num <= num + 4'h1;
    end
  end
  fc_hold_a: assert property (
    fc_tvalid && !fc_tready |=> fc_tvalid && $stable(fc_tdata))
    else $error("flow request not held");
  fc_format_a: assert property (
    fc_tvalid |-> fc_tdata[15:9] == FC_PAD && fc_tdata[7:0] == FC_PAUSE)
    else $error("flow request badly packed");
  fc_toggle_a: assert property (
    fc_take |-> fc_tdata[8] != last_stop)
    else $error("stop bit did not alternate");
  fc_pace_a: assert property (
    fc_take |=> !fc_tvalid [*8])
    else $error("flow request too soon after accept");
  k_hold_a: assert property (
    k_tx_tvalid && !k_tx_tready |=> k_tx_tvalid && $stable(k_tx_tdata))
    else $error("control block not held");
  k_format_a: assert property (
    k_tx_tvalid |-> k_tx_tdata[63:60] == BLK_PAD && k_tx_tdata[55:0] == KDATA_CONST)
    else $error("control block badly packed");
  k_number_a: assert property (
    k_take |-> k_tx_tdata[59:56] == num)
    else $error("control block number wrong");
  k_gap_a: assert property (
    k_take |=> !k_tx_tvalid [*4])
    else $error("control block gap too short");
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// top bench
module tb_top
  import ltg_pkg::*;
;
  logic ref_clk, rst_b, up, fc_ready, k_ready, stream_mode;
  logic rx_valid, rx_last, ufc_valid, ufc_last, k_valid, fc_taken_valid, k_taken_valid;
  logic [DATA_W-1:0] rx_data, ufc_data, k_data, k_taken;
  logic [FC_W-1:0] fc_taken;
  logic [KEEP_W-1:0] rx_keep, ufc_keep;
  logic [1:0] fc_state;
  logic [DATA_W-1:0] e_k;
  logic [FC_W-1:0] e_fc;
  logic [ERR_W-1:0] data_err_count, ufc_err_count, ctrl_err_count, e_data, e_ufc, e_ctrl;
  logic [15:0] s_rx, s_ufc;
  logic [31:0] seed, r;
  int num_errors, n_tests, cyc, n_fc;
  logic [FC_W-1:0] q_fc[$];
  logic [DATA_W-1:0] q_k[$];
  ltg_link_if lnk();
  ltg_gen_chk i_ltg_gen_chk (.ref_clk(ref_clk), .rst_b(rst_b), .ctrl_block_gap(16'h0004),
    .stream_mode(stream_mode), .lnk(lnk), .data_err_count(data_err_count),
    .ufc_err_count(ufc_err_count), .ctrl_err_count(ctrl_err_count), .fc_state(fc_state));
  ltg_core_end i_ltg_core_end (.ref_clk(ref_clk), .rst_b(rst_b), .lnk(lnk), .up(up),
    .fc_ready(fc_ready), .k_ready(k_ready), .rx_data(rx_data), .rx_keep(rx_keep),
    .rx_valid(rx_valid), .rx_last(rx_last), .ufc_data(ufc_data), .ufc_keep(ufc_keep),
    .ufc_valid(ufc_valid), .ufc_last(ufc_last), .k_data(k_data), .k_valid(k_valid),
    .fc_taken(fc_taken), .fc_taken_valid(fc_taken_valid), .k_taken(k_taken),
    .k_taken_valid(k_taken_valid));
  ltg_link_monitor i_ltg_link_monitor (.ref_clk(ref_clk), .rst_b(rst_b),
    .fc_tdata(lnk.fc_tdata), .fc_tvalid(lnk.fc_tvalid), .fc_tready(lnk.fc_tready),
    .k_tx_tdata(lnk.k_tx_tdata), .k_tx_tvalid(lnk.k_tx_tvalid), .k_tx_tready(lnk.k_tx_tready));
  // ========================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[14] ^ s[12] ^ s[3]};
  endfunction
  function automatic logic [7:0] sat(input logic [7:0] c);
    return (c == 8'hff) ? c : c + 8'h01;
  endfunction
  task automatic cmp_cnt(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_fc(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_blk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // readies stall at random so both handshakes see waits
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge ref_clk);
      r = rnd();
      fc_ready = r[24] | r[25];
      k_ready = r[26] | r[27];
    end
  endtask
  // expectations restart with every reset
  task automatic fill();
    q_fc.delete();
    q_k.delete();
    s_rx = LFSR_SEED;
    s_ufc = UFC_SEED;
    e_data = 8'h00;
    e_ufc = 8'h00;
    e_ctrl = 8'h00;
    for (int i = 0; i < 512; i++) begin
      q_fc.push_back({FC_PAD, ~i[0], FC_PAUSE});
      q_k.push_back({BLK_PAD, (i < 8) ? 4'(i) : BLK_LAST, KDATA_CONST});
    end
  endtask
  // idle beats carry inverted garbage, which must not be counted
  task automatic drive(input int n, input int pbad);
    logic [DATA_W-1:0] d_rx, d_u, d_k;
    logic [31:0] kp;
    for (int i = 0; i < n; i++) begin
      tick(1);
      kp = rnd();
      d_rx = ~rx_data;
      d_u = ~ufc_data;
      d_k = ~k_data;
      rx_valid = r[31:30] != 2'b00;
      rx_last = rx_valid && i[1:0] == 2'b11;
      rx_keep = kp[KEEP_W-1:0];
      ufc_keep = kp[8 +: KEEP_W];
      if (rx_valid) begin
        d_rx = {4{s_rx}};
        d_u = {4{s_ufc}};
        d_k = {BLK_PAD, 1'b0, r[10:8], KDATA_CONST};
        s_rx = step(s_rx);
        s_ufc = step(s_ufc);
        if (r[7:0] % 100 < pbad) begin
          d_rx[r[5:0]] = ~d_rx[r[5:0]];
          // a dropped byte on a framed last beat is never compared
          if (!rx_last || stream_mode || rx_keep[r[5:3]]) begin
            e_data = sat(e_data);
          end
        end
        if (r[15:8] % 100 < pbad) begin
          d_u[r[13:8]] = ~d_u[r[13:8]];
          if (!rx_last || ufc_keep[r[13:11]]) begin
            e_ufc = sat(e_ufc);
          end
        end
        if (r[23:16] % 100 < pbad) begin
          d_k[r[21:16] % 56] = ~d_k[r[21:16] % 56];
          e_ctrl = sat(e_ctrl);
        end
      end
      ufc_valid = rx_valid;
      k_valid = rx_valid;
      ufc_last = rx_last;
      rx_data = d_rx;
      ufc_data = d_u;
      k_data = d_k;
    end
  endtask
  task automatic settle();
    tick(1);
    rx_valid = 1'b0;
    ufc_valid = 1'b0;
    k_valid = 1'b0;
    tick(4);
    cmp_cnt("data errors", e_data, data_err_count);
    cmp_cnt("flow errors", e_ufc, ufc_err_count);
    cmp_cnt("block errors", e_ctrl, ctrl_err_count);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ========================================
  // watchers
  // looked at mid-cycle, away from the edge that launches them; an empty queue is a mismatch
  always @(negedge ref_clk) begin
    if (fc_taken_valid === 1'b1) begin
      n_fc++;
      e_fc = (q_fc.size() > 0) ? q_fc.pop_front() : {FC_W{1'b1}};
      cmp_fc("flow request", e_fc, fc_taken);
    end
    if (k_taken_valid === 1'b1) begin
      e_k = (q_k.size() > 0) ? q_k.pop_front() : {DATA_W{1'b1}};
      cmp_blk("control block", e_k, k_taken);
    end
  end
  // whole run needs about 1240 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // ========================================
  // main sequence
  initial begin
    {rst_b, up, fc_ready, k_ready, stream_mode} = 5'h00;
    {rx_valid, rx_last, ufc_valid, ufc_last, k_valid} = 5'h00;
    {rx_data, ufc_data, k_data, rx_keep, ufc_keep} = '0;
    seed = 32'd41;
    {num_errors, n_tests, cyc, n_fc} = '0;
    fill();
    tick(10);
    rst_b = 1'b1;
    tick(2);
    up = 1'b1;
    drive(200, 10);
    settle();
    cmp_cnt("flow state active", 8'h01, {7'h00, fc_state != 2'b00});
    stream_mode = 1'b1;
    drive(200, 10);
    settle();
    drive(400, 100);
    settle();
    rst_b = 1'b0;
    fill();
    tick(3);
    cmp_cnt("data errors in reset", 8'h00, data_err_count);
    cmp_cnt("block errors in reset", 8'h00, ctrl_err_count);
    cmp_cnt("flow errors in reset", 8'h00, ufc_err_count);
    cmp_cnt("flow state in reset", 8'h00, {6'h00, fc_state});
    rst_b = 1'b1;
    stream_mode = 1'b0;
    tick(2);
    drive(300, 5);
    settle();
    tick(100);
    cmp_cnt("flow requests seen", 8'h01, {7'h00, n_fc > 4});
    results();
  end
endmodule
`default_nettype wire
